// ---- verilog/parallel_line_io_unit.sv ----
// parallel line unit: bus slave, output latch, input gate
`timescale 1ns/1ps
`default_nettype none
`include "parallel_line_io_unit_cfg.svh"

// Overview of operation
// - read mux: status, output, vector; input apart
// - status bits 7, 15 mirror requests
// - four writable bits: cmd0, cmd1, enables
// - command bits drive user output lines
// - input read gates live lines, no storage
// - input read sends data-taken pulse
// - output buffer: two byte latches
// - every output write sends new-data pulse
// - enabled request raises bus interrupt
// - acknowledge drives requesting source's vector
// - loopback returns output, commands drive requests
// - initialize clears state, copied to user
// - address bits 3-12 match straps
// - low digit 0/2/4 picks register
// - vector bits 3-7 from straps
// - unused status bits read zero
// - loopback initialize clears request bits
// - every strobe to offset 0, 2 or 4 gets a reply
// - output buffer reads back last write
module parallel_line_io_unit (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [15:0] bus_addr_data_lines_n_i,
	output logic      [15:0] bus_addr_data_lines_n_o,
	output logic             bus_addr_data_lines_oe,
	input  wire logic        bus_sync_n,
	input  wire logic        bus_read_strobe_n,
	input  wire logic        bus_write_strobe_n,
	input  wire logic        bus_byte_n,
	input  wire logic        bus_init_n,
	input  wire logic        iack_chain_in_n,
	output logic             iack_chain_out_n,
	output logic             bus_reply_n,
	output logic             bus_irq_n,
	input  wire logic [9:0]  addr_strap_removed,
	input  wire logic [4:0]  vec_strap_removed,
	input  wire logic        loopback_mode,
	input  wire logic [15:0] user_in_lines,
	input  wire logic        user_req_a,
	input  wire logic        user_req_b,
	output logic      [15:0] user_out_lines,
	output logic             user_cmd_bit0,
	output logic             user_cmd_bit1,
	output logic             new_data_pulse,
	output logic             in_taken_pulse,
	output logic             user_init_a
);
	// --------------------------------------------------------
	// state and internal nets
	// --------------------------------------------------------
	parallel_line_io_pkg::core_state_t state_q;
	parallel_line_io_pkg::core_state_t state_d;
	logic [`PIN_W-1:0]                 raw_pins;
	logic                              req_a_eff;
	logic                              req_b_eff;
	logic                              pulse_start;
	logic [7:0]                        pulse_len;
	logic                              pulse_busy;

	pin_bundle_if pins_bus ();

	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------

	function automatic logic addr_match(
		input logic [15:0] addr,
		input logic [9:0]  straps
	);
		return (addr[15:13] == `IO_PAGE_BITS) && (addr[12:3] == straps);
	endfunction

	function automatic logic reg_hit(
		input logic [2:0] ofs,
		input logic [2:0] base
	);
		// byte address bit is not part of the register choice
		return ofs[2:1] == base[2:1];
	endfunction

	function automatic logic [15:0] csr_word(
		input logic cmd0,
		input logic cmd1,
		input logic en_a,
		input logic en_b,
		input logic req_a,
		input logic req_b
	);
		logic [15:0] w;
		w                 = 16'h0000;
		w[`CSR_CMD0_BIT]  = cmd0;
		w[`CSR_CMD1_BIT]  = cmd1;
		w[`CSR_ENB_B_BIT] = en_b;
		w[`CSR_ENB_A_BIT] = en_a;
		w[`CSR_REQ_A_BIT] = req_a;
		w[`CSR_REQ_B_BIT] = req_b;
		return w;
	endfunction

	function automatic logic [15:0] vector_word(
		input logic [4:0] straps,
		input logic       src_b
	);
		return {8'h00, straps, (src_b ? `VEC_B_LOW : `VEC_A_LOW)};
	endfunction

	// --------------------------------------------------------
	// pin synchroniser
	// --------------------------------------------------------
	// bus pins and requests synchronised
	// active-low pins are flipped here so that reset reads idle
	assign raw_pins = {
		loopback_mode,
		user_req_b,
		user_req_a,
		!iack_chain_in_n,
		!bus_init_n,
		!bus_byte_n,
		!bus_write_strobe_n,
		!bus_read_strobe_n,
		!bus_sync_n,
		~bus_addr_data_lines_n_i
	};

	pin_sync pin_sync_inst (
		.mclk (mclk),
		.nrst (nrst),
		.raw  (raw_pins),
		.pins (pins_bus.drv)
	);

	// --------------------------------------------------------
	// strobe pulse timer
	// --------------------------------------------------------
	// pulse widths counted
	strobe_timer strobe_timer_inst (
		.mclk  (mclk),
		.nrst  (nrst),
		.start (pulse_start),
		.len   (pulse_len),
		.busy  (pulse_busy)
	);

	// --------------------------------------------------------
	// request lines
	// --------------------------------------------------------
	always_comb begin
		if (pins_bus.maint) begin
			req_a_eff = state_q.cmd0;
			req_b_eff = state_q.cmd1;
		end else begin
			req_a_eff = pins_bus.req_a;
			req_b_eff = pins_bus.req_b;
		end
	end

	// --------------------------------------------------------
	// next state
	// --------------------------------------------------------
	always_comb begin
		state_d           = state_q;
		pulse_start       = 1'b0;
		pulse_len         = 8'h00;
		state_d.arm       = 1'b0;
		state_d.sync_prev = pins_bus.sync;
		state_d.init_out  = pins_bus.init;

		if (pins_bus.sync && !state_q.sync_prev) begin
			state_d.sel = addr_match(pins_bus.dal, addr_strap_removed) &&
				(pins_bus.dal[2:1] != 2'b11);
			state_d.ofs = pins_bus.dal[2:0];
		end else if (!pins_bus.sync) begin
			state_d.sel = 1'b0;
		end

		state_d.irq_n = !((req_a_eff && state_q.en_a) ||
			(req_b_eff && state_q.en_b));
		state_d.iack_out_n = !(pins_bus.iack && state_q.irq_n);

		case (state_q.st)
			parallel_line_io_pkg::ST_IDLE: begin
				if (pins_bus.din && pins_bus.iack && !state_q.irq_n) begin
					// requesting source's vector
					// request A wins when both are pending
					state_d.dal_out_n = ~vector_word(vec_strap_removed,
						!(req_a_eff && state_q.en_a));
					state_d.dal_oe    = 1'b1;
					state_d.reply_n   = 1'b0;
					state_d.st        = parallel_line_io_pkg::ST_REPLY;
				end else if (state_q.sel && pins_bus.din) begin
					state_d.dal_oe = 1'b1;
					if (reg_hit(state_q.ofs, `OFS_INPUT_BUFFER)) begin
						pulse_start   = 1'b1;
						pulse_len     = 8'(`DT_PULSE_CYC);
						state_d.taken = 1'b1;
						state_d.arm   = 1'b1;
						state_d.st    = parallel_line_io_pkg::ST_PULSE;
					end else begin
						if (reg_hit(state_q.ofs, `OFS_OUTPUT_BUFFER)) begin
							state_d.dal_out_n = ~state_q.outbuf;
						end else begin
							state_d.dal_out_n = ~csr_word(state_q.cmd0,
								state_q.cmd1, state_q.en_a, state_q.en_b,
								req_a_eff, req_b_eff);
						end
						state_d.reply_n = 1'b0;
						state_d.st      = parallel_line_io_pkg::ST_REPLY;
					end
				end else if (state_q.sel && pins_bus.dout) begin
					if (reg_hit(state_q.ofs, `OFS_OUTPUT_BUFFER)) begin
						if (!pins_bus.wtbt || !state_q.ofs[0]) begin
							state_d.outbuf[7:0] = pins_bus.dal[7:0];
						end
						if (!pins_bus.wtbt || state_q.ofs[0]) begin
							state_d.outbuf[15:8] = pins_bus.dal[15:8];
						end
						pulse_start      = 1'b1;
						pulse_len        = 8'(`NDR_PULSE_CYC);
						state_d.new_data = 1'b1;
						state_d.arm      = 1'b1;
						state_d.st       = parallel_line_io_pkg::ST_PULSE;
					end else begin
						// four writable status bits
						// all four sit in the low byte
						if (reg_hit(state_q.ofs, `OFS_CONTROL_STATUS) &&
							(!pins_bus.wtbt || !state_q.ofs[0])) begin
							state_d.cmd0 = pins_bus.dal[`CSR_CMD0_BIT];
							state_d.cmd1 = pins_bus.dal[`CSR_CMD1_BIT];
							state_d.en_b = pins_bus.dal[`CSR_ENB_B_BIT];
							state_d.en_a = pins_bus.dal[`CSR_ENB_A_BIT];
						end
						state_d.reply_n = 1'b0;
						state_d.st      = parallel_line_io_pkg::ST_REPLY;
					end
				end
			end
			parallel_line_io_pkg::ST_PULSE: begin
				if (state_q.taken) begin
					// live lines gated, unstored
					// the user holds them until the pulse ends, so
					// no synchroniser is spent on this path
					if (pins_bus.maint) begin
						state_d.dal_out_n = ~state_q.outbuf;
					end else begin
						state_d.dal_out_n = ~user_in_lines;
					end
				end
				if (!state_q.arm && !pulse_busy) begin
					state_d.new_data = 1'b0;
					state_d.taken    = 1'b0;
					state_d.reply_n  = 1'b0;
					state_d.st       = parallel_line_io_pkg::ST_REPLY;
				end
			end
			parallel_line_io_pkg::ST_REPLY: begin
				if (!pins_bus.din && !pins_bus.dout) begin
					state_d.reply_n   = 1'b1;
					state_d.dal_oe    = 1'b0;
					state_d.dal_out_n = 16'hFFFF;
					state_d.st        = parallel_line_io_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d.st = parallel_line_io_pkg::ST_IDLE;
			end
		endcase

		// initialize clears state
		// loopback requests follow the cleared commands
		if (pins_bus.init) begin
			state_d.outbuf = `OUTBUF_RST;
			state_d.cmd0   = `CMD_RST;
			state_d.cmd1   = `CMD_RST;
			state_d.en_a   = `CMD_RST;
			state_d.en_b   = `CMD_RST;
			state_d.irq_n  = 1'b1;
		end
	end

	// --------------------------------------------------------
	// state register
	// --------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q            <= '0;
			state_q.dal_out_n  <= 16'hFFFF;
			state_q.reply_n    <= 1'b1;
			state_q.irq_n      <= 1'b1;
			state_q.iack_out_n <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	// --------------------------------------------------------
	// outputs, all straight from the state register
	// --------------------------------------------------------
	assign bus_addr_data_lines_n_o = state_q.dal_out_n;
	assign bus_addr_data_lines_oe  = state_q.dal_oe;
	assign bus_reply_n             = state_q.reply_n;
	assign bus_irq_n               = state_q.irq_n;
	assign iack_chain_out_n        = state_q.iack_out_n;
	assign user_out_lines          = state_q.outbuf;
	assign user_cmd_bit0           = state_q.cmd0;
	assign user_cmd_bit1           = state_q.cmd1;
	assign new_data_pulse          = state_q.new_data;
	assign in_taken_pulse          = state_q.taken;
	assign user_init_a             = state_q.init_out;
endmodule

`default_nettype wire

// ---- verilog/parallel_line_io_unit_cfg.svh ----
// offsets, field positions, reset values and timing counts
`ifndef PARALLEL_LINE_IO_UNIT_CFG_SVH
`define PARALLEL_LINE_IO_UNIT_CFG_SVH

// register offsets within the selected block (low address digit)
`define OFS_CONTROL_STATUS 3'h0
`define OFS_OUTPUT_BUFFER  3'h2
`define OFS_INPUT_BUFFER   3'h4

// control/status field positions
`define CSR_CMD0_BIT  0
`define CSR_CMD1_BIT  1
`define CSR_ENB_B_BIT 5
`define CSR_ENB_A_BIT 6
`define CSR_REQ_A_BIT 7
`define CSR_REQ_B_BIT 15

// register block sits in the top 8K of the 16-bit space
`define IO_PAGE_BITS  3'h7

// vector offset of request B above request A
`define VEC_B_LOW     3'h4
`define VEC_A_LOW     3'h0

// reset values
`define OUTBUF_RST    16'h0000
`define CMD_RST       1'b0

// strobe timing, clock period and pulse widths in ns
`define CLK_PERIOD_NS 8
`define NDR_PULSE_NS  350
`define DT_PULSE_NS   1150
`define NDR_PULSE_CYC \
	((`NDR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DT_PULSE_CYC \
	((`DT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// synchroniser bundle width
`define PIN_W 25

`endif

// ---- verilog/parallel_line_io_pkg.sv ----
// types shared by the parallel line unit modules
`include "parallel_line_io_unit_cfg.svh"

package parallel_line_io_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PULSE,
		ST_REPLY
	} bus_st_t;

	typedef struct packed {
		logic [`PIN_W-1:0] s1;
		logic [`PIN_W-1:0] s2;
		logic [`PIN_W-1:0] s3;
		logic [`PIN_W-1:0] clean;
	} sync_state_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic       busy;
	} timer_state_t;

	typedef struct packed {
		bus_st_t     st;
		logic        sync_prev;
		logic        sel;
		logic [2:0]  ofs;
		logic        cmd0;
		logic        cmd1;
		logic        en_a;
		logic        en_b;
		logic [15:0] outbuf;
		logic [15:0] dal_out_n;
		logic        dal_oe;
		logic        reply_n;
		logic        irq_n;
		logic        iack_out_n;
		logic        new_data;
		logic        taken;
		logic        arm;
		logic        init_out;
	} core_state_t;

endpackage

// ---- verilog/pin_bundle_if.sv ----
// synchronised pin bundle between synchroniser and core
`timescale 1ns/1ps
`default_nettype none

interface pin_bundle_if;
	logic [15:0] dal;
	logic        sync;
	logic        din;
	logic        dout;
	logic        wtbt;
	logic        init;
	logic        iack;
	logic        req_a;
	logic        req_b;
	logic        maint;

	modport drv (
		output dal, sync, din, dout, wtbt, init, iack,
		output req_a, req_b, maint
	);
	modport core (
		input dal, sync, din, dout, wtbt, init, iack,
		input req_a, req_b, maint
	);
endinterface

`default_nettype wire

// ---- verilog/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "parallel_line_io_unit_cfg.svh"

module pin_sync (
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic [`PIN_W-1:0] raw,
	pin_bundle_if.drv              pins
);
	parallel_line_io_pkg::sync_state_t q;
	parallel_line_io_pkg::sync_state_t d;

	// --------------------------------------------------------
	// filter
	// --------------------------------------------------------
	always_comb begin
		d    = q;
		d.s1 = raw;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// a bit moves only once stages two and three agree
		for (int i = 0; i < `PIN_W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.clean[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pins.dal   = q.clean[15:0];
	assign pins.sync  = q.clean[16];
	assign pins.din   = q.clean[17];
	assign pins.dout  = q.clean[18];
	assign pins.wtbt  = q.clean[19];
	assign pins.init  = q.clean[20];
	assign pins.iack  = q.clean[21];
	assign pins.req_a = q.clean[22];
	assign pins.req_b = q.clean[23];
	assign pins.maint = q.clean[24];
endmodule

`default_nettype wire

// ---- verilog/strobe_timer.sv ----
// down-counter that times user strobe pulses
`timescale 1ns/1ps
`default_nettype none

module strobe_timer (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic [7:0] len,
	output logic            busy
);
	parallel_line_io_pkg::timer_state_t q;
	parallel_line_io_pkg::timer_state_t d;

	always_comb begin
		d = q;
		if (start) begin
			d.busy = 1'b1;
			d.cnt  = len - 8'h01;
		end else if (q.busy) begin
			if (q.cnt == 8'h00) begin
				d.busy = 1'b0;
			end else begin
				d.cnt = q.cnt - 8'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign busy = q.busy;
endmodule

`default_nettype wire

// ---- verification/parallel_line_io_unit_assertions.sv ----
// pin checker for the parallel unit
`timescale 1ns/1ps
`default_nettype none
module parallel_line_io_unit_chk (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        bus_read_strobe_n,
	input wire logic        bus_write_strobe_n,
	input wire logic        bus_init_n,
	input wire logic        iack_chain_in_n,
	input wire logic        bus_reply_n,
	input wire logic        bus_irq_n,
	input wire logic        user_init_a,
	input wire logic        bus_addr_data_lines_oe,
	input wire logic        new_data_pulse,
	input wire logic        in_taken_pulse,
	input wire logic [15:0] user_out_lines
);
	wire r = !bus_read_strobe_n, w = !bus_write_strobe_n, i = !bus_init_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	property p_clr; i[*8] |-> user_out_lines == 16'h0000; endproperty
	a_clr: assert property (p_clr) else $error("clr");
	property p_ini; i[*8] |-> user_init_a; endproperty
	a_ini: assert property (p_ini) else $error("ini");
	property p_irq; i[*8] |-> bus_irq_n; endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_ndr; $rose(new_data_pulse) |-> w; endproperty
	a_ndr: assert property (p_ndr) else $error("ndr");
	property p_dt; $rose(in_taken_pulse) |-> r; endproperty
	a_dt: assert property (p_dt) else $error("dt");
	property p_rpl; $fell(bus_reply_n) |-> r || w; endproperty
	a_rpl: assert property (p_rpl) else $error("rpl");
	property p_oe; $rose(bus_addr_data_lines_oe) |-> r; endproperty
	a_oe: assert property (p_oe) else $error("oe");
	// latch only moves under a write or initialize
	property p_out; $changed(user_out_lines) |-> w || i; endproperty
	a_out: assert property (p_out) else $error("out");
	c_ndr: cover property ($rose(new_data_pulse));
	c_dt: cover property ($rose(in_taken_pulse));
	property p_vec;
		$fell(bus_reply_n) && !iack_chain_in_n |-> bus_addr_data_lines_oe;
	endproperty
	a_vec: assert property (p_vec) else $error("vec");
	c_irq: cover property ($fell(bus_irq_n));
	c_vec: cover property ($fell(bus_reply_n) && !iack_chain_in_n);
endmodule
bind parallel_line_io_unit parallel_line_io_unit_chk
	parallel_line_io_unit_chk_inst (.*);
`default_nettype wire

// ---- verification/user_dev.sv ----
// user device model on the far side of the unit
`timescale 1ns/1ps
`default_nettype none
module user_dev (
	input wire logic mclk, t, n,
	input wire logic [15:0] o,
	output logic [15:0] i = 16'hA5C3,
	output logic [15:0] cap
);
	logic tq = 1'b0, nq = 1'b0;
	always @(posedge mclk) begin
		tq <= t;
		nq <= n;
		if (tq && !t) i <= ~i ^ 16'h0101;
		if (nq && !n) cap <= o;
	end
endmodule
`default_nettype wire

// ---- verification/test_parallel_line_io_unit.sv ----
// self-checking bench for the parallel unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin comparisons++; if ((s)!==(e)) begin errors++; \
	$display("unexpected %s exp %h got %h",n,e,s); end end
module test_parallel_line_io_unit;
	logic mclk=0, nrst=0, bus_sync_n=1, bus_read_strobe_n=1, bus_byte_n=1;
	logic bus_write_strobe_n=1, bus_init_n=1, loopback_mode=0, user_req_a=0;
	logic user_req_b=0, iack_chain_out_n, bus_reply_n, bus_irq_n, user_init_a;
	logic bus_addr_data_lines_oe, user_cmd_bit0, user_cmd_bit1, new_data_pulse;
	logic in_taken_pulse, iack_chain_in_n=1;
	logic [15:0] bus_addr_data_lines_n_i=16'hFFFF, bus_addr_data_lines_n_o;
	logic [15:0] user_in_lines, user_out_lines, cap, rd, o, v;
	int errors=0, comparisons=0;
	parallel_line_io_unit parallel_line_io_unit_inst (.*,
		.addr_strap_removed(10'h1FF), .vec_strap_removed(5'h18));
	user_dev user_dev_inst (.mclk, .t(in_taken_pulse), .n(new_data_pulse),
		.o(user_out_lines), .i(user_in_lines), .cap);
	always #4 mclk = ~mclk;
	task automatic end_sim;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// address phase, then data phase; strobes held until the reply
	// ia: interrupt acknowledge read, no address phase
	task automatic cyc(logic w, b, logic [2:0] a, logic [15:0] d,
		logic ia = 1'b0);
		bus_addr_data_lines_n_i <= ~{13'h1DFF, a};
		@(posedge mclk) bus_sync_n <= ia;
		repeat (4) @(posedge mclk);
		bus_addr_data_lines_n_i <= w ? ~d : 16'hFFFF;
		bus_byte_n <= b;
		bus_write_strobe_n <= !w;
		bus_read_strobe_n <= w;
		iack_chain_in_n <= !ia;
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 300 && bus_reply_n !== p[0]; k++) @(posedge mclk);
			if (bus_reply_n !== p[0]) begin errors++; end_sim; end
			if (!p) rd = ~bus_addr_data_lines_n_o;
			{bus_write_strobe_n, bus_read_strobe_n, iack_chain_in_n,
				bus_sync_n} <= {3'b111, p[0] | ia};
		end
		@(posedge mclk);
	endtask
	initial begin
		void'($urandom(17));
		repeat (2) @(posedge mclk);
		nrst <= 1;
		cyc(1, 1, 0, 16'hFFFF);
		`CHK("cmd", 2'b11, {user_cmd_bit1, user_cmd_bit0})
		for (int k = 0; k < 3; k++) begin
			{user_req_b, user_req_a} <= 2'(k);
			repeat (12) @(posedge mclk);
			cyc(0, 1, 0, 0);
			`CHK("csr", {k[1], 7'h00, k[0], 7'h63}, rd)
			`CHK("irq", k == 0, bus_irq_n)
			if (k != 0) begin
				cyc(0, 1, 0, 0, 1);
				`CHK("vec", k == 1 ? 16'h00C0 : 16'h00C4, rd)
			end
		end
		user_req_b <= 0;
		o = 16'($urandom);
		cyc(1, 1, 2, o);
		cyc(0, 1, 2, 0);
		`CHK("ob", {o, o}, {rd, user_out_lines})
		o[15:8] = 8'h5A;
		cyc(1, 0, 3, 16'h5A5A);
		repeat (60) @(posedge mclk);
		`CHK("cap", {o, o}, {user_out_lines, cap})
		v = user_in_lines;
		cyc(0, 1, 4, 0);
		repeat (150) @(posedge mclk);
		`CHK("in", {v, ~v ^ 16'h0101}, {rd, user_in_lines})
		loopback_mode <= 1;
		cyc(1, 1, 0, 16'h0001);
		cyc(0, 1, 0, 0);
		v = rd;
		cyc(0, 1, 4, 0);
		`CHK("lb", {16'h0081, o}, {v, rd})
		bus_init_n <= 0;
		repeat (10) @(posedge mclk);
		bus_init_n <= 1;
		cyc(0, 1, 0, 0);
		`CHK("init", 32'h00000000, {rd, user_out_lines})
		end_sim;
	end
endmodule
`default_nettype wire
